// ---- verilog/dlg_pkg.sv ----
// dlg_pkg: register map, field layout, reset values and lookup constants
// for the demodulator loop gain configuration block.
// assumes: one 100 MHz clock; 8-bit registers on a 6-bit register address.
package dlg_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          REG_AW       = 6;
  localparam int          REG_DW       = 8;
  localparam logic [5:0]  FOC_ADDR     = 6'h19;
  localparam logic [5:0]  BS_ADDR      = 6'h1A;
  localparam logic [7:0]  FOC_RESET    = 8'h36;
  localparam logic [7:0]  BS_RESET     = 8'h6C;
  localparam logic [7:0]  FOC_WMASK    = 8'h3F;
  localparam logic [7:0]  BS_WMASK     = 8'hFF;
  localparam logic [7:0]  RDATA_NONE   = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FOC_GATE_BIT   = 5;
  localparam int FOC_PRE_LSB    = 3;
  localparam int FOC_POST_BIT   = 2;
  localparam int FOC_SAT_LSB    = 0;
  localparam int BS_KI_PRE_LSB  = 6;
  localparam int BS_KP_PRE_LSB  = 4;
  localparam int BS_KI_POST_BIT = 3;
  localparam int BS_KP_POST_BIT = 2;
  localparam int BS_SAT_LSB     = 0;

  // ---------------------------------------------------------------
  // gains in units of half the base gain (K/2, KI/2, KP/2)
  // ---------------------------------------------------------------
  localparam logic [3:0] GAIN_HALF  = 4'h1;
  localparam logic [3:0] GAIN_UNIT  = 4'h2;

  // saturation codes
  localparam logic [1:0] SAT_NONE   = 2'h0;
  localparam logic [1:0] SAT_LOW    = 2'h1;
  localparam logic [1:0] SAT_MID    = 2'h2;
  localparam logic [1:0] SAT_HIGH   = 2'h3;

  // frequency limit as channel bandwidth shifted right
  localparam int FSAT_SHIFT_LOW  = 3;
  localparam int FSAT_SHIFT_MID  = 2;
  localparam int FSAT_SHIFT_HIGH = 1;

  // rate limit in 1/256 of the data rate: 3.125, 6.25, 12.5 percent
  localparam logic [5:0] RSAT_LOW   = 6'h08;
  localparam logic [5:0] RSAT_MID   = 6'h10;
  localparam logic [5:0] RSAT_HIGH  = 6'h20;

  // relative carrier sense, rssi counted in half dB
  localparam int         RSSI_STEPS_PER_DB = 2;
  localparam int         REL_THR1_DB       = 6;
  localparam logic [8:0] REL_THR1_STEPS    = 9'(REL_THR1_DB * RSSI_STEPS_PER_DB);
  localparam logic [7:0] RSSI_REF_RESET    = 8'h7F;

  typedef struct packed {
    logic [3:0] freq_gain;
    logic [3:0] integral_gain;
    logic [3:0] proportional_gain;
  } dlg_gains_t;

endpackage : dlg_pkg

// ---- verilog/dlg_loop_config.sv ----
// dlg_loop_config: loop gain registers and gain selection for the
// frequency compensation and clock recovery loops of the demodulator.
// assumes: register port, sync and carrier sense all synchronous to
// i_sys_clk; the loops themselves sit outside and consume the outputs.
//
// Function
// - With the sense gate set, both loops stay frozen until carrier sense is high; gate resets to 1.
// - Pre-sync frequency gain is K, 2K, 3K or 4K from a two-bit field reset to 10.
// - Post-sync frequency gain is the pre-sync gain or K/2 from one bit reset to 1.
// - Frequency offset saturates at none, BW/8, BW/4 or BW/2 from a field reset to 10.
// - Pre-sync integral gain is KI, 2KI, 3KI or 4KI from a two-bit field reset to 01.
// - Pre-sync proportional gain is KP, 2KP, 3KP or 4KP from a two-bit field reset to 10.
// - Post-sync integral gain is the pre-sync gain or KI/2 from one bit reset to 1.
// - Post-sync proportional gain is the pre-sync gain or KP from one bit reset to 1.
// - Data rate offset saturates at none, 3.125, 6.25 or 12.5 percent, reset to 00.
// - Relative threshold setting 1 asserts carrier sense on a 6 dB rise in rssi.
`timescale 1ns/1ns
module dlg_loop_config
  import dlg_pkg::*;
#(
  parameter int BW_W = 8
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_arst_n,
  input  wire logic [REG_AW-1:0] i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [REG_DW-1:0] i_reg_wdata,
  output logic      [REG_DW-1:0] o_reg_rdata,
  input  wire logic              i_sync_found,
  input  wire logic              i_carrier_sense,
  input  wire logic              i_rx_restart,
  input  wire logic [1:0]        i_relative_sense_threshold,
  input  wire logic [7:0]        i_rssi,
  input  wire logic              i_rssi_valid,
  input  wire logic [BW_W-1:0]   i_channel_bandwidth,
  output logic                   o_loops_freeze,
  output logic                   o_sense,
  output dlg_gains_t             o_gains,
  output logic      [BW_W-1:0]   o_freq_sat_limit,
  output logic      [5:0]        o_rate_sat_lim
);

  if (BW_W < 4) begin : g_bw_check
    $error("dlg_loop_config: BW_W must be at least 4");
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [REG_DW-1:0] foc_q, foc_d;
  logic [REG_DW-1:0] bs_q, bs_d;
  logic [REG_DW-1:0] rdata_d;

  always_comb begin
    foc_d   = foc_q;
    bs_d    = bs_q;
    rdata_d = o_reg_rdata;
    if (i_reg_wr && i_reg_addr == FOC_ADDR) begin
      foc_d = i_reg_wdata & FOC_WMASK;
    end
    if (i_reg_wr && i_reg_addr == BS_ADDR) begin
      bs_d = i_reg_wdata & BS_WMASK;
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        FOC_ADDR: rdata_d = foc_q & FOC_WMASK;
        BS_ADDR:  rdata_d = bs_q;
        default:  rdata_d = RDATA_NONE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      foc_q       <= FOC_RESET;
      bs_q        <= BS_RESET;
      o_reg_rdata <= RDATA_NONE;
    end else begin
      foc_q       <= foc_d;
      bs_q        <= bs_d;
      o_reg_rdata <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // relative carrier sense
  // ---------------------------------------------------------------
  // baseline is the lowest rssi seen since the last restart; a noise
  // floor that drifts upward is not tracked, restart to re-arm.
  logic [7:0]        rssi_ref_q, rssi_ref_d;
  logic              rel_q, rel_d;
  logic signed [8:0] rssi_rise;
  logic              rel_hit;

  always_comb begin
    rssi_rise  = $signed({i_rssi[7], i_rssi}) - $signed({rssi_ref_q[7], rssi_ref_q});
    rel_hit    = (i_relative_sense_threshold == SAT_LOW)
               && (rssi_rise >= $signed(REL_THR1_STEPS));
    rssi_ref_d = rssi_ref_q;
    rel_d      = rel_q;
    if (i_rx_restart) begin
      rssi_ref_d = RSSI_REF_RESET;
      rel_d      = 1'b0;
    end else if (i_rssi_valid) begin
      if ($signed(i_rssi) < $signed(rssi_ref_q)) begin
        rssi_ref_d = i_rssi;
      end
      rel_d = rel_q | rel_hit;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rssi_ref_q <= RSSI_REF_RESET;
      rel_q      <= 1'b0;
    end else begin
      rssi_ref_q <= rssi_ref_d;
      rel_q      <= rel_d;
    end
  end

  // ---------------------------------------------------------------
  // gain selection and saturation
  // ---------------------------------------------------------------
  logic       sense_now;
  logic       freeze_d, sense_d;
  dlg_gains_t gains_d;
  logic [3:0] foc_pre_x, ki_pre_x, kp_pre_x;
  logic [BW_W-1:0] fsat_d;
  logic [5:0] rsat_d;

  always_comb begin
    sense_now = i_carrier_sense | rel_q;
    sense_d   = sense_now;
    freeze_d  = foc_q[FOC_GATE_BIT] & ~sense_now;
    foc_pre_x = {1'b0, foc_q[FOC_PRE_LSB +: 2], 1'b0} + GAIN_UNIT;
    ki_pre_x  = {1'b0, bs_q[BS_KI_PRE_LSB +: 2], 1'b0} + GAIN_UNIT;
    kp_pre_x  = {1'b0, bs_q[BS_KP_PRE_LSB +: 2], 1'b0} + GAIN_UNIT;
    gains_d.freq_gain         = foc_pre_x;
    gains_d.integral_gain     = ki_pre_x;
    gains_d.proportional_gain = kp_pre_x;
    if (i_sync_found) begin
      if (foc_q[FOC_POST_BIT]) gains_d.freq_gain = GAIN_HALF;
      if (bs_q[BS_KI_POST_BIT]) gains_d.integral_gain = GAIN_HALF;
      if (bs_q[BS_KP_POST_BIT]) gains_d.proportional_gain = GAIN_UNIT;
    end
    unique case (foc_q[FOC_SAT_LSB +: 2])
      SAT_LOW:  fsat_d = i_channel_bandwidth >> FSAT_SHIFT_LOW;
      SAT_MID:  fsat_d = i_channel_bandwidth >> FSAT_SHIFT_MID;
      SAT_HIGH: fsat_d = i_channel_bandwidth >> FSAT_SHIFT_HIGH;
      SAT_NONE: fsat_d = '0;
    endcase
    unique case (bs_q[BS_SAT_LSB +: 2])
      SAT_LOW:  rsat_d = RSAT_LOW;
      SAT_MID:  rsat_d = RSAT_MID;
      SAT_HIGH: rsat_d = RSAT_HIGH;
      SAT_NONE: rsat_d = '0;
    endcase
  end

  // ook needs zero frequency saturation; software owns that, nothing checked here
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_loops_freeze   <= 1'b0;
      o_sense          <= 1'b0;
      o_gains          <= '0;
      o_freq_sat_limit <= '0;
      o_rate_sat_lim   <= '0;
    end else begin
      o_loops_freeze   <= freeze_d;
      o_sense          <= sense_d;
      o_gains          <= gains_d;
      o_freq_sat_limit <= fsat_d;
      o_rate_sat_lim   <= rsat_d;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // checks arm one edge after reset release: outputs launched on the
  // release edge itself still carry reset values, not the configuration
  logic chk_live_q, chk_live_d;

  always_comb begin
    chk_live_d = 1'b1;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chk_live_q <= 1'b0;
    end else begin
      chk_live_q <= chk_live_d;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n || !chk_live_q);

  // gain code n selects n + 1 base gains, expressed in half units

  AST_FREEZE_HOLD: assert property (
    (foc_q[FOC_GATE_BIT] && !i_carrier_sense && !rel_q) |=> o_loops_freeze)
    else $error("loops not frozen while gate set and no carrier");

  AST_FREEZE_RELEASE: assert property (
    i_carrier_sense |=> !o_loops_freeze && o_sense)
    else $error("loops still frozen with carrier sense high");

  AST_FREQ_PRE: assert property (
    !i_sync_found
      |=> o_gains.freq_gain
          == ({2'b00, $past(foc_q[FOC_PRE_LSB +: 2])} + 4'h1) * GAIN_UNIT)
    else $error("pre-sync frequency gain wrong");

  AST_FREQ_POST: assert property (
    (i_sync_found && foc_q[FOC_POST_BIT]) |=> o_gains.freq_gain == GAIN_HALF)
    else $error("post-sync frequency gain not K/2");

  AST_FREQ_SAT_NONE: assert property (
    (foc_q[FOC_SAT_LSB +: 2] == SAT_NONE) |=> o_freq_sat_limit == '0)
    else $error("frequency saturation not zero");

  AST_KI_POST: assert property (
    (i_sync_found && !bs_q[BS_KI_POST_BIT])
      |=> o_gains.integral_gain
          == ({2'b00, $past(bs_q[BS_KI_PRE_LSB +: 2])} + 4'h1) * GAIN_UNIT)
    else $error("post-sync integral gain not pre-sync value");

  AST_KP_POST: assert property (
    (i_sync_found && bs_q[BS_KP_POST_BIT]) |=> o_gains.proportional_gain == GAIN_UNIT)
    else $error("post-sync proportional gain not KP");

  AST_RATE_SAT: assert property (
    (bs_q[BS_SAT_LSB +: 2] == SAT_HIGH) |=> o_rate_sat_lim == RSAT_HIGH)
    else $error("rate saturation not 12.5 percent");

  AST_REL_SENSE: assert property (
    (i_rssi_valid && !i_rx_restart && rel_hit && !i_carrier_sense) |=> ##1 o_sense)
    else $error("relative carrier sense missed a 6 dB rise");

  AST_FOC_UPPER: assert property (
    (i_reg_rd && i_reg_addr == FOC_ADDR) |=> o_reg_rdata[7:6] == 2'h0)
    else $error("unused frequency register bits read nonzero");

  AST_FREQ_KEEP: assert property (
    (i_sync_found && !foc_q[FOC_POST_BIT])
      |=> o_gains.freq_gain
          == ({2'b00, $past(foc_q[FOC_PRE_LSB +: 2])} + 4'h1) * GAIN_UNIT)
    else $error("post-sync frequency gain not pre-sync value");

  AST_KI_PRE: assert property (
    !i_sync_found
      |=> o_gains.integral_gain
          == ({2'b00, $past(bs_q[BS_KI_PRE_LSB +: 2])} + 4'h1) * GAIN_UNIT)
    else $error("pre-sync integral gain wrong");

  AST_KP_PRE: assert property (
    !i_sync_found
      |=> o_gains.proportional_gain
          == ({2'b00, $past(bs_q[BS_KP_PRE_LSB +: 2])} + 4'h1) * GAIN_UNIT)
    else $error("pre-sync proportional gain wrong");

  AST_KI_HALF: assert property (
    (i_sync_found && bs_q[BS_KI_POST_BIT]) |=> o_gains.integral_gain == GAIN_HALF)
    else $error("post-sync integral gain not half the base gain");

  AST_KP_KEEP: assert property (
    (i_sync_found && !bs_q[BS_KP_POST_BIT])
      |=> o_gains.proportional_gain
          == ({2'b00, $past(bs_q[BS_KP_PRE_LSB +: 2])} + 4'h1) * GAIN_UNIT)
    else $error("post-sync proportional gain not pre-sync value");

  AST_FREQ_SAT_LOW: assert property (
    (foc_q[FOC_SAT_LSB +: 2] == SAT_LOW)
      |=> o_freq_sat_limit == BW_W'($past(i_channel_bandwidth[BW_W-1:FSAT_SHIFT_LOW])))
    else $error("frequency saturation not bandwidth/8");

  AST_FREQ_SAT_MID: assert property (
    (foc_q[FOC_SAT_LSB +: 2] == SAT_MID)
      |=> o_freq_sat_limit == BW_W'($past(i_channel_bandwidth[BW_W-1:FSAT_SHIFT_MID])))
    else $error("frequency saturation not bandwidth/4");

  AST_FREQ_SAT_HIGH: assert property (
    (foc_q[FOC_SAT_LSB +: 2] == SAT_HIGH)
      |=> o_freq_sat_limit == BW_W'($past(i_channel_bandwidth[BW_W-1:FSAT_SHIFT_HIGH])))
    else $error("frequency saturation not bandwidth/2");

  AST_RATE_SAT_LOW: assert property (
    (bs_q[BS_SAT_LSB +: 2] == SAT_LOW) |=> o_rate_sat_lim == RSAT_LOW)
    else $error("rate saturation not 3.125 percent");

  AST_RATE_SAT_MID: assert property (
    (bs_q[BS_SAT_LSB +: 2] == SAT_MID) |=> o_rate_sat_lim == RSAT_MID)
    else $error("rate saturation not 6.25 percent");

  AST_RATE_SAT_NONE: assert property (
    (bs_q[BS_SAT_LSB +: 2] == SAT_NONE) |=> o_rate_sat_lim == '0)
    else $error("rate saturation not zero");

  AST_FOC_STORE: assert property (
    (i_reg_wr && i_reg_addr == FOC_ADDR)
      |=> foc_q[REG_DW-1:FOC_GATE_BIT+1] == '0
          && foc_q[FOC_GATE_BIT:0] == $past(i_reg_wdata[FOC_GATE_BIT:0]))
    else $error("frequency register write stored wrongly");

  AST_RESTART_CLEAR: assert property (
    i_rx_restart |=> !rel_q && rssi_ref_q == RSSI_REF_RESET)
    else $error("restart did not re-arm relative carrier sense");

  AST_FREEZE_OPEN: assert property (
    !foc_q[FOC_GATE_BIT] |=> !o_loops_freeze)
    else $error("loops frozen with sense gate clear");

endmodule : dlg_loop_config

// ---- tb/dlg_loop_config_tb_top.sv ----
// dlg_loop_config_tb_top: self-checking bench for the loop gain block.
// assumes: assertions sit in the design; the bench drives every port itself.
`timescale 1ns/1ns
module dlg_loop_config_tb_top
  import dlg_pkg::*;
();
  `define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end

  logic             clk = 1'b0;
  logic             arst_n = 1'b0;
  logic [5:0]       addr = 6'h00;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic [7:0]       wdata = 8'h00;
  logic             sync = 1'b0;
  logic             cs = 1'b0;
  logic             restart = 1'b0;
  logic [1:0]       rel = 2'h0;
  logic [7:0]       rssi = 8'h00;
  logic             rssi_v = 1'b0;
  logic [7:0]       bw = 8'hA0;
  logic [7:0]       rdata;
  logic             freeze;
  logic             sense;
  dlg_gains_t       gains;
  logic [7:0]       fsat;
  logic [5:0]       rsat;
  int               failures = 0;
  int               n_checks = 0;

  always #5 clk = ~clk;

  dlg_loop_config #(.BW_W(8)) i_dut (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sync_found(sync),
    .i_carrier_sense(cs), .i_rx_restart(restart), .i_relative_sense_threshold(rel),
    .i_rssi(rssi), .i_rssi_valid(rssi_v), .i_channel_bandwidth(bw),
    .o_loops_freeze(freeze), .o_sense(sense), .o_gains(gains),
    .o_freq_sat_limit(fsat), .o_rate_sat_lim(rsat));

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rd_chk

  // two edges cover the config-to-output latency
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic rssi_smp(input logic [7:0] v);
    @(posedge clk);
    rssi   <= v;
    rssi_v <= 1'b1;
    @(posedge clk);
    rssi_v <= 1'b0;
  endtask : rssi_smp

  task automatic rx_restart;
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask : rx_restart

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // watchdog: whole sequence needs well under 2000 cycles
  // ---------------------------------------------------------------
  initial begin
    #100000;
    failures++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [3:0] g;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    `CHK(gains, dlg_gains_t'({4'h6, 4'h4, 4'h6}))
    `CHK({freeze, fsat, rsat}, {1'b1, 8'h28, 6'h00})
    rd_chk(FOC_ADDR, 8'h36);
    rd_chk(BS_ADDR, 8'h6C);
    rd_chk(6'h1B, 8'h00);
    // unmapped write must leave both registers alone
    wr_reg(6'h1B, 8'hFF);
    rd_chk(FOC_ADDR, 8'h36);
    rd_chk(BS_ADDR, 8'h6C);
    wr_reg(FOC_ADDR, 8'hFF);
    rd_chk(FOC_ADDR, 8'h3F);
    // every pre-sync gain code and saturation code, gate open
    for (int c = 0; c < 4; c++) begin
      wr_reg(FOC_ADDR, {3'b000, 2'(c), 1'b0, 2'(c)});
      wr_reg(BS_ADDR, {2'(c), 2'(c), 2'b00, 2'(c)});
      settle();
      g = 4'(2 * (c + 1));
      `CHK(gains, dlg_gains_t'({g, g, g}))
      `CHK(fsat, (c == 0) ? 8'h00 : (bw >> (4 - c)))
      `CHK(rsat, (c == 0) ? 6'h00 : 6'(6'h04 << c))
      `CHK(freeze, 1'b0)
    end
    // post-sync selection, both settings, sync held high
    wr_reg(FOC_ADDR, 8'h1C);
    wr_reg(BS_ADDR, 8'hFC);
    sync <= 1'b1;
    settle();
    `CHK(gains, dlg_gains_t'({4'h1, 4'h1, 4'h2}))
    // software keeps frequency saturation at zero, as on-off keying needs
    `CHK(fsat, 8'h00)
    wr_reg(FOC_ADDR, 8'h18);
    wr_reg(BS_ADDR, 8'hF0);
    settle();
    `CHK(gains, dlg_gains_t'({4'h8, 4'h8, 4'h8}))
    @(posedge clk);
    sync <= 1'b0;
    // gate holds loops until carrier sense
    wr_reg(FOC_ADDR, 8'h20);
    settle();
    `CHK(freeze, 1'b1)
    @(posedge clk);
    cs <= 1'b1;
    settle();
    `CHK({freeze, sense}, 2'b01)
    @(posedge clk);
    cs <= 1'b0;
    // relative sense: 5.5 dB rise is not enough, 6 dB is
    rel <= 2'h1;
    rx_restart();
    rssi_smp(8'hB0);
    rssi_smp(8'hBB);
    settle();
    `CHK({freeze, sense}, 2'b10)
    rssi_smp(8'hBC);
    settle();
    `CHK({freeze, sense}, 2'b01)
    rx_restart();
    settle();
    `CHK(sense, 1'b0)
    @(posedge clk);
    rel <= 2'h2;
    rssi_smp(8'hB0);
    rssi_smp(8'hC0);
    settle();
    `CHK(sense, 1'b0)
    // second reset in mid-run restores defaults
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(FOC_ADDR, 8'h36);
    rd_chk(BS_ADDR, 8'h6C);
    `CHK(gains, dlg_gains_t'({4'h6, 4'h4, 4'h6}))
    `CHK({freeze, fsat, rsat}, {1'b1, 8'h28, 6'h00})
    end_of_test();
  end
endmodule : dlg_loop_config_tb_top
